/* hw/mac_cmd_pkg.sv */
package mac_cmd_pkg;

  // ------------------------------------------------------------
  // command encodings
  // ------------------------------------------------------------
  localparam logic [7:0] OP_VERIFY = 8'h28;
  localparam logic [7:0] OP_COUNTER = 8'h24;
  localparam logic [7:0] MODE_COPY_A = 8'h01;
  localparam logic [7:0] MODE_COPY_B = 8'h05;
  localparam int MODE_CHAL_TK = 0;
  localparam int MODE_KEY_TK = 1;
  localparam int MODE_FLAG = 2;
  localparam int MODE_INC = 0;

  // result and error bytes; error values are plain defaults
  localparam logic [7:0] RES_MATCH = 8'h00;
  localparam logic [7:0] RES_MISMATCH = 8'h01;
  localparam logic [7:0] ERR_PARSE = 8'h03;
  localparam logic [7:0] ERR_EXEC = 8'h0f;
  localparam logic [2:0] LEN_BYTE = 3'd1;
  localparam logic [2:0] LEN_COUNT = 3'd4;

  // ------------------------------------------------------------
  // counters and data layout
  // ------------------------------------------------------------
  localparam logic [20:0] COUNT_MAX = 21'h1f_ffff;
  localparam logic [6:0] DATA_LEN = 7'd77;
  localparam logic [6:0] MSG_LEN = 7'd88;
  localparam logic [6:0] MSG_CHAL = 7'd32;
  localparam logic [6:0] MSG_X0 = 7'd64;
  localparam logic [6:0] MSG_ZERO = 7'd68;
  localparam logic [6:0] MSG_X4 = 7'd76;
  localparam logic [6:0] MSG_SER8 = 7'd79;
  localparam logic [6:0] MSG_X7 = 7'd80;
  localparam logic [6:0] MSG_SER0 = 7'd84;
  localparam logic [6:0] MSG_X11 = 7'd86;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RESULT = 8'h10;
  localparam logic [7:0] REG_COUNT0 = 8'h14;
  localparam logic [7:0] REG_COUNT1 = 8'h18;
  localparam int CTRL_START = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_AUTH = 2;
  localparam int ST_TKVALID = 3;
  localparam int ST_TKFLAG = 4;
  localparam int ST_TKRNG = 5;
  localparam int ST_LIMIT = 6;
  localparam int ST_LEN = 8;
  localparam int ST_AUTHIDX = 12;

endpackage

/* hw/mac_message_mux.sv */
module mac_message_mux (
  // byte index into the hashed message
  input wire logic [6:0] idx,
  // message sources
  input wire logic [255:0] key,
  input wire logic [255:0] chal,
  input wire logic [103:0] extra,
  input wire logic [71:0] serial_number,
  // selected byte
  output logic [7:0] msg_byte
);

  // ------------------------------------------------------------
  // fixed message layout
  // ------------------------------------------------------------
  logic [6:0] r;

  always_comb begin
    r = 7'd0;
    msg_byte = 8'h00;
    if (idx < mac_cmd_pkg::MSG_CHAL) begin
      msg_byte = key[8*idx +: 8];
    end else if (idx < mac_cmd_pkg::MSG_X0) begin
      r = 7'(idx - mac_cmd_pkg::MSG_CHAL);
      msg_byte = chal[8*r +: 8];
    end else if (idx < mac_cmd_pkg::MSG_ZERO) begin
      r = 7'(idx - mac_cmd_pkg::MSG_X0);
      msg_byte = extra[8*r +: 8];
    end else if (idx < mac_cmd_pkg::MSG_X4) begin
      msg_byte = 8'h00;
    end else if (idx < mac_cmd_pkg::MSG_SER8) begin
      r = 7'(idx - mac_cmd_pkg::MSG_X4 + 7'd4);
      msg_byte = extra[8*r +: 8];
    end else if (idx < mac_cmd_pkg::MSG_X7) begin
      msg_byte = serial_number[71:64];
    end else if (idx < mac_cmd_pkg::MSG_SER0) begin
      r = 7'(idx - mac_cmd_pkg::MSG_X7 + 7'd7);
      msg_byte = extra[8*r +: 8];
    end else if (idx < mac_cmd_pkg::MSG_X11) begin
      r = 7'(idx - mac_cmd_pkg::MSG_SER0);
      msg_byte = serial_number[8*r +: 8];
    end else if (idx < mac_cmd_pkg::MSG_LEN) begin
      r = 7'(idx - mac_cmd_pkg::MSG_X11 + 7'd11);
      msg_byte = extra[8*r +: 8];
    end
  end

endmodule // mac_message_mux

/* hw/mac_check_and_counter_cmds.sv */
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module mac_check_and_counter_cmds (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // hash engine
  output logic msg_valid,
  output logic [7:0] msg_byte,
  output logic msg_last,
  input wire logic msg_ready,
  input wire logic digest_valid,
  input wire logic [255:0] digest,
  // key slots and configuration
  output logic [3:0] key_rd_index,
  input wire logic [255:0] key_rd_data,
  input wire logic [15:0] require_random_nonce,
  input wire logic [63:0] slot_read_key_field,
  input wire logic [71:0] serial_number,
  // temp key loading from other commands
  input wire logic tk_load,
  input wire logic [255:0] tk_value,
  input wire logic tk_source_flag,
  input wire logic tk_from_rng,
  // authorization
  input wire logic auth_clear,
  output logic authorization_valid_flag,
  output logic [3:0] authorized_key_index,
  // counter 0 key use and preset
  input wire logic key_use,
  input wire logic counter0_preset_load,
  input wire logic [20:0] counter0_preset_value,
  output logic key_use_refused,
  output logic counter0_limit_reached
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_HASH, ST_WAIT, ST_COPY} cmd_state_e;

  typedef struct packed {
    cmd_state_e st;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic rd_pend;
    logic wr_pend;
    logic [7:0] addr;
    logic [7:0] opcode;
    logic [7:0] mode;
    logic [15:0] key_index;
    logic [76:0][7:0] dbuf;
    logic [6:0] dcnt;
    logic [255:0] kbuf;
    logic [255:0] temp_key_register;
    logic tk_valid;
    logic temp_key_source_flag_a;
    logic tk_rng;
    logic auth_valid;
    logic [3:0] auth_idx;
    logic [1:0][20:0] cnt;
    logic cnt0_limit;
    logic refused;
    logic [3:0] rd_index;
    logic msg_valid;
    logic [7:0] msg_byte;
    logic msg_last;
    logic [6:0] midx;
    logic [31:0] result;
    logic [2:0] resp_len;
    logic done;
  } cmd_state_s;

  localparam cmd_state_s RESET_STATE = '{st: ST_IDLE, hreadyout: 1'b1, default: '0};

  cmd_state_s s_q;
  cmd_state_s s_d;
  logic start_cmd;
  logic [7:0] mux_byte;
  logic [255:0] chal_src;

  // returns {ok, next}; a counter at its maximum is never incremented
  function automatic logic [21:0] cnt_step(input logic [20:0] v);
    cnt_step = {v != mac_cmd_pkg::COUNT_MAX, 21'(v + 21'd1)};
  endfunction

  function automatic logic [3:0] copy_target(input logic [3:0] k);
    copy_target = k[0] ? k : 4'(k + 4'd1);
  endfunction

  assign start_cmd = s_q.wr_pend && (s_q.addr == mac_cmd_pkg::REG_CTRL)
                     && hwdata[mac_cmd_pkg::CTRL_START] && (s_q.st == ST_IDLE);
  assign chal_src = s_q.mode[mac_cmd_pkg::MODE_CHAL_TK] ? s_q.temp_key_register
                    : s_q.dbuf[31:0];

  mac_message_mux u_mux (
    .idx(s_q.midx),
    .key(s_q.kbuf),
    .chal(chal_src),
    .extra(s_q.dbuf[76:64]),
    .serial_number(serial_number),
    .msg_byte(mux_byte)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] rdv;
    logic [21:0] step;
    logic fin;
    logic [7:0] fin_code;
    logic [3:0] tgt;
    logic sel;
    rdv = 32'h0000_0000;
    step = 22'h00_0000;
    fin = 1'b0;
    fin_code = 8'h00;
    tgt = 4'h0;
    sel = 1'b0;
    s_d = s_q;
    s_d.hreadyout = 1'b1;
    s_d.hresp = 1'b0;
    s_d.refused = 1'b0;

    // reads get one wait state so a write just before is already visible
    if (s_q.rd_pend) begin
      if (s_q.addr == mac_cmd_pkg::REG_CMD) begin
        rdv = {s_q.key_index, s_q.mode, s_q.opcode};
      end else if (s_q.addr == mac_cmd_pkg::REG_DATA) begin
        rdv = {25'h000_0000, s_q.dcnt};
      end else if (s_q.addr == mac_cmd_pkg::REG_STATUS) begin
        rdv[mac_cmd_pkg::ST_BUSY] = s_q.st != ST_IDLE;
        rdv[mac_cmd_pkg::ST_DONE] = s_q.done;
        rdv[mac_cmd_pkg::ST_AUTH] = s_q.auth_valid;
        rdv[mac_cmd_pkg::ST_TKVALID] = s_q.tk_valid;
        rdv[mac_cmd_pkg::ST_TKFLAG] = s_q.temp_key_source_flag_a;
        rdv[mac_cmd_pkg::ST_TKRNG] = s_q.tk_rng;
        rdv[mac_cmd_pkg::ST_LIMIT] = s_q.cnt0_limit;
        rdv[mac_cmd_pkg::ST_LEN +: 3] = s_q.resp_len;
        rdv[mac_cmd_pkg::ST_AUTHIDX +: 4] = s_q.auth_idx;
      end else if (s_q.addr == mac_cmd_pkg::REG_RESULT) begin
        rdv = s_q.result;
      end else if (s_q.addr == mac_cmd_pkg::REG_COUNT0) begin
        rdv = {11'h000, s_q.cnt[0]};
      end else if (s_q.addr == mac_cmd_pkg::REG_COUNT1) begin
        rdv = {11'h000, s_q.cnt[1]};
      end
      s_d.hrdata = rdv;
      s_d.rd_pend = 1'b0;
    end

    // writes land in the data phase; command fields are frozen while busy
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      if (s_q.st == ST_IDLE) begin
        if (s_q.addr == mac_cmd_pkg::REG_CMD) begin
          s_d.opcode = hwdata[7:0];
          s_d.mode = hwdata[15:8];
          s_d.key_index = hwdata[31:16];
        end else if (s_q.addr == mac_cmd_pkg::REG_DATA) begin
          // challenge, response, extra data in arrival order
          if (s_q.dcnt < mac_cmd_pkg::DATA_LEN) begin
            s_d.dbuf[s_q.dcnt] = hwdata[7:0];
            s_d.dcnt = 7'(s_q.dcnt + 7'd1);
          end
        end else if (s_q.addr == mac_cmd_pkg::REG_CTRL) begin
          if (hwdata[mac_cmd_pkg::CTRL_CLEAR]) begin
            s_d.dcnt = 7'd0;
          end
        end
      end
    end

    if (hsel && htrans[1] && hready) begin
      s_d.addr = haddr[7:0];
      s_d.wr_pend = hwrite;
      s_d.rd_pend = !hwrite;
      s_d.hreadyout = hwrite;
    end

    // outside events; copy and command set below win over these
    if (auth_clear) begin
      s_d.auth_valid = 1'b0;
    end
    if (tk_load) begin
      s_d.temp_key_register = tk_value;
      s_d.tk_valid = 1'b1;
      s_d.temp_key_source_flag_a = tk_source_flag;
      s_d.tk_rng = tk_from_rng;
    end
    if (counter0_preset_load && (s_q.st == ST_IDLE)) begin
      s_d.cnt[0] = counter0_preset_value;
    end

    // ------------------------------------------------------------
    // command sequencing
    // ------------------------------------------------------------
    case (s_q.st)
      ST_IDLE: begin
        if (start_cmd) begin
          s_d.done = 1'b0;
          if (s_q.opcode == mac_cmd_pkg::OP_VERIFY) begin
            if (s_q.mode[7:3] != 5'h00) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_PARSE;
            end else if (s_q.dcnt != mac_cmd_pkg::DATA_LEN) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_PARSE;
            end else if ((s_q.mode[1] | s_q.mode[0])
                         && (s_q.mode[mac_cmd_pkg::MODE_FLAG] != s_q.temp_key_source_flag_a
                             || !s_q.tk_valid)) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_EXEC;
            end else if (require_random_nonce[s_q.key_index[3:0]] && !s_q.tk_rng) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_EXEC;
            end else begin
              s_d.rd_index = s_q.key_index[3:0];
              s_d.st = ST_FETCH;
            end
          end else if (s_q.opcode == mac_cmd_pkg::OP_COUNTER) begin
            sel = s_q.key_index[0];
            if (s_q.mode[7:1] != 7'h00) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_PARSE;
            end else if (s_q.key_index > 16'h0001) begin
              fin = 1'b1;
              fin_code = mac_cmd_pkg::ERR_PARSE;
            end else if (s_q.mode[mac_cmd_pkg::MODE_INC]) begin
              step = cnt_step(s_d.cnt[sel]);
              if (!step[21]) begin
                fin = 1'b1;
                fin_code = mac_cmd_pkg::ERR_EXEC;
              end else begin
                // single-edge commit: the count is never half written
                s_d.cnt[sel] = step[20:0];
                s_d.result = {11'h000, step[20:0]};
                s_d.resp_len = mac_cmd_pkg::LEN_COUNT;
                s_d.done = 1'b1;
              end
            end else begin
              s_d.result = {11'h000, s_d.cnt[sel]};
              s_d.resp_len = mac_cmd_pkg::LEN_COUNT;
              s_d.done = 1'b1;
            end
          end else begin
            fin = 1'b1;
            fin_code = mac_cmd_pkg::ERR_PARSE;
          end
        end
      end
      ST_FETCH: begin
        // slot data is read with the index flop already settled
        s_d.kbuf = s_q.mode[mac_cmd_pkg::MODE_KEY_TK] ? s_q.temp_key_register
                   : key_rd_data;
        s_d.midx = 7'd0;
        s_d.st = ST_HASH;
      end
      ST_HASH: begin
        if (!s_q.msg_valid || msg_ready) begin
          if (s_q.midx == mac_cmd_pkg::MSG_LEN) begin
            s_d.msg_valid = 1'b0;
            s_d.msg_last = 1'b0;
            s_d.st = ST_WAIT;
          end else begin
            s_d.msg_valid = 1'b1;
            s_d.msg_byte = mux_byte;
            s_d.msg_last = s_q.midx == 7'(mac_cmd_pkg::MSG_LEN - 7'd1);
            s_d.midx = 7'(s_q.midx + 7'd1);
          end
        end
      end
      ST_WAIT: begin
        if (digest_valid) begin
          s_d.resp_len = mac_cmd_pkg::LEN_BYTE;
          if (digest == s_q.dbuf[63:32]) begin
            s_d.result = {24'h00_0000, mac_cmd_pkg::RES_MATCH};
            if (!s_q.mode[mac_cmd_pkg::MODE_KEY_TK]) begin
              s_d.auth_valid = 1'b1;
              s_d.auth_idx = s_q.key_index[3:0];
            end
            if (s_q.mode == mac_cmd_pkg::MODE_COPY_A || s_q.mode == mac_cmd_pkg::MODE_COPY_B) begin
              s_d.rd_index = copy_target(s_q.key_index[3:0]);
              s_d.st = ST_COPY;
            end else begin
              s_d.done = 1'b1;
              s_d.st = ST_IDLE;
            end
          end else begin
            s_d.result = {24'h00_0000, mac_cmd_pkg::RES_MISMATCH};
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
        end
      end
      ST_COPY: begin
        // limited use and final use settings are deliberately not consulted
        tgt = s_q.rd_index;
        if (slot_read_key_field[4*tgt +: 4] == 4'h0) begin
          s_d.temp_key_register = key_rd_data;
          s_d.tk_valid = 1'b1;
        end
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    if (fin) begin
      s_d.result = {24'h00_0000, fin_code};
      s_d.resp_len = mac_cmd_pkg::LEN_BYTE;
      s_d.done = 1'b1;
      s_d.st = ST_IDLE;
    end

    // only counter 0 is ever tied to key use
    if (key_use) begin
      step = cnt_step(s_d.cnt[0]);
      if (step[21]) begin
        s_d.cnt[0] = step[20:0];
      end else begin
        s_d.refused = 1'b1;
      end
    end
    s_d.cnt0_limit = s_d.cnt[0] == mac_cmd_pkg::COUNT_MAX;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hreadyout;
  assign hresp = s_q.hresp;
  assign hrdata = s_q.hrdata;
  assign msg_valid = s_q.msg_valid;
  assign msg_byte = s_q.msg_byte;
  assign msg_last = s_q.msg_last;
  assign key_rd_index = s_q.rd_index;
  assign authorization_valid_flag = s_q.auth_valid;
  assign authorized_key_index = s_q.auth_idx;
  assign key_use_refused = s_q.refused;
  assign counter0_limit_reached = s_q.cnt0_limit;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [3:0] key_lo;
  assign key_lo = s_q.key_index[3:0];

  sequence s_dig_match;
    s_q.st == ST_WAIT && digest_valid && digest == s_q.dbuf[63:32];
  endsequence
  sequence s_cnt_start;
    start_cmd && s_q.opcode == mac_cmd_pkg::OP_COUNTER && s_q.key_index <= 16'h0001
      && !key_use && !counter0_preset_load;
  endsequence

  property p_verify_match;
    s_dig_match |=> s_q.result[7:0] == mac_cmd_pkg::RES_MATCH && s_q.resp_len == 3'd1;
  endproperty
  a_verify_match: assert property (p_verify_match) else $error("match not reported");

  property p_verify_miss;
    s_q.st == ST_WAIT && digest_valid && digest != s_q.dbuf[63:32]
      |=> s_q.result[7:0] == mac_cmd_pkg::RES_MISMATCH && s_q.done && s_q.st == ST_IDLE;
  endproperty
  a_verify_miss: assert property (p_verify_miss) else $error("mismatch not reported");

  property p_auth_set;
    s_dig_match ##0 (!s_q.mode[1] && !auth_clear)
      |=> authorization_valid_flag && authorized_key_index == $past(key_lo);
  endproperty
  a_auth_set: assert property (p_auth_set) else $error("authorization not recorded");

  property p_copy_target;
    s_dig_match ##0 (s_q.mode == 8'h01 || s_q.mode == 8'h05)
      |=> s_q.st == ST_COPY && key_rd_index == copy_target($past(key_lo));
  endproperty
  a_copy_target: assert property (p_copy_target) else $error("wrong copy slot");

  property p_flag_mismatch;
    start_cmd && s_q.opcode == mac_cmd_pkg::OP_VERIFY && s_q.mode[7:3] == 5'h00
      && s_q.dcnt == 7'd77 && s_q.mode[0] && s_q.mode[2] != s_q.temp_key_source_flag_a
      |=> s_q.result[7:0] == mac_cmd_pkg::ERR_EXEC ##1 s_q.st == ST_IDLE;
  endproperty
  a_flag_mismatch: assert property (p_flag_mismatch) else $error("flag check missed");

  property p_sel_parse;
    start_cmd && s_q.opcode == mac_cmd_pkg::OP_COUNTER && s_q.mode[7:1] == 7'h00
      && s_q.key_index > 16'h0001
      |=> s_q.result[7:0] == mac_cmd_pkg::ERR_PARSE && s_q.resp_len == 3'd1;
  endproperty
  a_sel_parse: assert property (p_sel_parse) else $error("bad selector accepted");

  property p_cnt_sat;
    s_cnt_start ##0 (s_q.mode == 8'h01 && s_q.cnt[key_lo[0]] == mac_cmd_pkg::COUNT_MAX)
      |=> s_q.result[7:0] == mac_cmd_pkg::ERR_EXEC
      && s_q.cnt[key_lo[0]] == mac_cmd_pkg::COUNT_MAX;
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("saturated counter moved");

  property p_cnt_inc;
    s_cnt_start ##0 (s_q.mode == 8'h01 && s_q.cnt[key_lo[0]] != mac_cmd_pkg::COUNT_MAX)
      |=> s_q.cnt[key_lo[0]] == 21'($past(s_q.cnt[key_lo[0]]) + 21'd1)
      && s_q.resp_len == 3'd4;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("increment wrong");

  property p_cnt_read;
    s_cnt_start ##0 (s_q.mode == 8'h00)
      |=> $stable(s_q.cnt[key_lo[0]]) && s_q.result == {11'h000, s_q.cnt[key_lo[0]]}
      && s_q.resp_len == 3'd4;
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("read changed counter");

  property p_read_wait;
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");

endmodule // mac_check_and_counter_cmds

/* tb/hash_stub.sv */
module hash_stub (
  // clock
  input wire logic clk,
  // message and digest
  input wire logic msg_valid,
  input wire logic [7:0] msg_byte,
  input wire logic msg_last,
  output logic msg_ready = 0,
  output logic digest_valid = 0,
  output logic [255:0] digest,
  // bench view
  input wire logic [255:0] dig,
  output logic [6:0] n_last = 0,
  output logic [7:0] first = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  int seed = 32'h867a;
  logic [6:0] cnt = 0;
  logic [3:0] dly = 0;
  // outside its pulse the digest bus shows garbage, not the last value
  assign digest = digest_valid ? dig : ~dig;
  always @(posedge clk) begin
    msg_ready <= 1'($random(seed));
    digest_valid <= (dly == 4'h1);
    if (dly != 0)
      dly <= dly - 4'h1;
    if (msg_valid && msg_ready) begin
      if (cnt == 0)
        first <= msg_byte;
      cnt <= cnt + 7'h1;
      if (msg_last) begin
        n_last <= cnt + 7'h1;
        cnt <= 0;
        dly <= 4'h9;
      end
    end
  end
endmodule // hash_stub

/* tb/mac_check_and_counter_cmds_test.sv */
module mac_check_and_counter_cmds_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, tk_load = 0, tk_source_flag = 0;
  logic tk_from_rng = 0, key_use = 0, counter0_preset_load = 0, hreadyout, hresp;
  logic msg_valid, msg_last, msg_ready, digest_valid, key_use_refused;
  logic authorization_valid_flag, counter0_limit_reached;
  logic [1:0] htrans = 0;
  logic [3:0] key_rd_index, authorized_key_index;
  logic [6:0] n_last;
  logic [7:0] msg_byte, first;
  logic [20:0] counter0_preset_value = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, last;
  logic [255:0] digest, dig = 0, tk_value = 0;
  logic [31:0] q[$];
  int n_errors = 0, n_tests = 0, seed = 32'h867a;
  event rd_ev;
  mac_check_and_counter_cmds dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .msg_valid, .msg_byte, .msg_last, .msg_ready, .digest_valid, .digest,
    .key_rd_index, .key_rd_data({32{4'h0, key_rd_index}}),
    .require_random_nonce(16'h0010), .slot_read_key_field(64'h0000_0000_0000_00f0),
    .serial_number(dig[71:0]), .tk_load, .tk_value, .tk_source_flag, .tk_from_rng,
    .auth_clear(1'b0), .authorization_valid_flag, .authorized_key_index, .key_use,
    .counter0_preset_load, .counter0_preset_value, .key_use_refused,
    .counter0_limit_reached);
  hash_stub hs (.clk, .msg_valid, .msg_byte, .msg_last, .msg_ready, .digest_valid,
    .digest, .dig, .n_last, .first);
  // ------------------------------------------------------------
  // checking
  // ------------------------------------------------------------
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(rd_ev) chk(last, q.pop_front());
  // ------------------------------------------------------------
  // bus and commands
  // ------------------------------------------------------------
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit c);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    last = hrdata;
    if (c)
      -> rd_ev;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    ahb(0, a, 0, 1);
  endtask
  task automatic run(input logic [7:0] op, md, input logic [15:0] k, input int nd, input bit ok);
    logic [7:0] b;
    ahb(1, mac_cmd_pkg::REG_CTRL, 32'h0000_0002, 0);
    ahb(1, mac_cmd_pkg::REG_CMD, {k, md, op}, 0);
    for (int i = 0; i < nd; i++) begin
      b = (i inside {[32:63]}) ? dig[8*(i-32)+:8] ^ {7'h0, !ok} : 8'($random(seed));
      ahb(1, mac_cmd_pkg::REG_DATA, {24'h0, b}, 0);
    end
    ahb(1, mac_cmd_pkg::REG_CTRL, 32'h0000_0001, 0);
    do ahb(0, mac_cmd_pkg::REG_STATUS, 0, 0); while (last[1:0] !== 2'b10);
  endtask
  task automatic cnt(input logic [7:0] md, input logic [15:0] k, input logic [31:0] e);
    run(mac_cmd_pkg::OP_COUNTER, md, k, 0, 0);
    rd(mac_cmd_pkg::REG_RESULT, e);
  endtask
  task automatic ver(input logic [7:0] md, input logic [15:0] k, input bit ok,
                     input logic [7:0] res, fb);
    run(mac_cmd_pkg::OP_VERIFY, md, k, 77, ok);
    rd(mac_cmd_pkg::REG_RESULT, {24'h0, res});
    if (res < 8'h02)
      chk({n_last, first}, {7'd88, fb});
  endtask
  // ------------------------------------------------------------
  // stimulus
  // ------------------------------------------------------------
  initial forever #20 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop;
  end
  initial begin
    dig = {8{$random(seed)}};
    repeat (2) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    cnt(8'h00, 16'h0001, 32'h0);
    cnt(8'h01, 16'h0001, 32'h1);
    cnt(8'h01, 16'h0001, 32'h2);
    cnt(8'h00, 16'h0002, {24'h0, mac_cmd_pkg::ERR_PARSE});
    cnt(8'h00, 16'h0100, {24'h0, mac_cmd_pkg::ERR_PARSE});
    cnt(8'h02, 16'h0000, {24'h0, mac_cmd_pkg::ERR_PARSE});
    counter0_preset_value <= mac_cmd_pkg::COUNT_MAX - 21'h1;
    counter0_preset_load <= 1;
    @(posedge clk);
    counter0_preset_load <= 0;
    cnt(8'h01, 16'h0000, {11'h0, mac_cmd_pkg::COUNT_MAX});
    chk({31'h0, counter0_limit_reached}, 32'h1);
    cnt(8'h01, 16'h0000, {24'h0, mac_cmd_pkg::ERR_EXEC});
    rd(mac_cmd_pkg::REG_COUNT0, {11'h0, mac_cmd_pkg::COUNT_MAX});
    key_use <= 1;
    @(posedge clk);
    key_use <= 0;
    @(posedge clk);
    chk({31'h0, key_use_refused}, 32'h1);
    ver(8'h00, 16'hff12, 1, mac_cmd_pkg::RES_MATCH, 8'h02);
    chk({27'h0, authorization_valid_flag, authorized_key_index}, 32'h12);
    ver(8'h00, 16'h0002, 0, mac_cmd_pkg::RES_MISMATCH, 8'h02);
    ver(8'h08, 16'h0002, 1, mac_cmd_pkg::ERR_PARSE, 8'h00);
    ver(8'h00, 16'h0004, 1, mac_cmd_pkg::ERR_EXEC, 8'h00);
    tk_value <= {32{8'h5a}};
    tk_source_flag <= 1;
    tk_load <= 1;
    @(posedge clk);
    tk_load <= 0;
    ver(8'h01, 16'h0002, 1, mac_cmd_pkg::ERR_EXEC, 8'h00);
    ver(8'h05, 16'h0002, 1, mac_cmd_pkg::RES_MATCH, 8'h02);
    ver(8'h06, 16'h0002, 1, mac_cmd_pkg::RES_MATCH, 8'h03);
    ver(8'h05, 16'h0000, 1, mac_cmd_pkg::RES_MATCH, 8'h00);
    ver(8'h06, 16'h0002, 1, mac_cmd_pkg::RES_MATCH, 8'h03);
    @(posedge clk);
    report_and_stop;
  end
endmodule // mac_check_and_counter_cmds_test
